//--- src/cam_pkg.sv
// Shared constants and types of the content-addressable memory block.
// Assumes one 25 MHz clock and a 32-bit Avalon-MM register slave.
package cam_pkg;
  // Array geometry
  localparam int unsigned WORDS = 32;
  localparam int unsigned WIDTH = 32;
  localparam int unsigned LINES = 16;
  localparam int unsigned FAST_WORDS = 16;
  localparam int unsigned RAM_DEPTH = 512;
  localparam int unsigned RAM_BITS = 8;
  localparam int unsigned BANK_BIT = 31;

  // Write cycle counts, plain and with don't-care bits
  localparam logic [1:0] WR_CYC = 2'h2;
  localparam logic [1:0] WR_CYC_DC = 2'h3;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_WDATA = 8'h04;
  localparam logic [7:0] OFS_WMASK = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_RESULT = 8'h14;
  localparam logic [7:0] OFS_RAMDATA = 8'h18;

  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  // Field positions
  localparam int unsigned OPT_DIN = 0;
  localparam int unsigned OPT_DOUT = 1;
  localparam int unsigned OPT_RADDR = 2;
  localparam int unsigned OPT_WADDR = 3;
  localparam int unsigned OPT_WE = 4;
  localparam int unsigned OPT_RD_STB = 5;
  localparam int unsigned CMD_OP_LSB = 0;
  localparam int unsigned CMD_ADDR_LSB = 16;
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_MATCH = 1;
  localparam int unsigned ST_ERR = 2;
  localparam int unsigned ST_PDN = 3;
  localparam int unsigned ST_ADDR_LSB = 8;
  localparam int unsigned RES_ADDR_LSB = 16;
  localparam int unsigned RES_MATCH = 24;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_MULTI = 2'h1,
    MODE_FAST = 2'h2,
    MODE_RAM = 2'h3
  } mode_e;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_CAM_WR = 3'h1,
    OP_SEARCH = 3'h2,
    OP_RAM_WR = 3'h3,
    OP_RAM_RD = 3'h4,
    OP_CLEAR = 3'h5
  } op_e;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_PREP = 6'h02,
    S_WR = 6'h04,
    S_SRCH = 6'h08,
    S_OUT2 = 6'h10,
    S_RAM = 6'h20
  } state_e;

  typedef struct packed {
    logic [15:0] rsvd;
    logic [3:0] out_div;
    logic [5:0] reg_opt;
    logic rom_lock;
    logic enable;
    logic low_power;
    logic unenc;
    mode_e mode;
  } ctrl_s;

  typedef struct packed {
    logic valid;
    logic match;
    logic [4:0] addr;
    logic [15:0] lines;
  } res_s;

  typedef struct packed {
    logic we;
    logic ram;
    logic [8:0] addr;
    logic [31:0] data;
    logic [31:0] mask;
  } cfg_s;
endpackage

//--- src/cam_word_cmp.sv
// One CAM entry comparator: search key against one stored word.
// Assumes the caller folds ignored key bits into the don't-care mask.
module cam_word_cmp #(
  parameter int unsigned WIDTH = 32
) (
  // Search side
  input wire logic [WIDTH-1:0] key,
  // Stored entry
  input wire logic [WIDTH-1:0] word,
  input wire logic [WIDTH-1:0] dont_care,
  input wire logic vld,
  // Result
  output logic hit
);
  // A marked bit always compares equal
  assign hit = vld & (&((key ~^ word) | dont_care));
endmodule

//--- src/cam_memory_block.sv
// Embedded memory block: 32x32 CAM, one 512x8 single-port RAM, lookup ROM.
// Assumes an Avalon-MM master and a config loader on the same clock.
//
// Function
// - Block splits into two single-port RAMs; here one 512x8 RAM with one port.
// - All registers clear from local, global, chip; here readdata_q, waitrequest_q and local_clr_q clear on rst only; cam_data, cam_mask, ram_mem never clear.
// - Search compares key against all words.
// - Match flag high when any word matches.
// - CAM holds thirty-two 32-bit words.
// - Don't-care bits ignored during compare.
// - Three search modes, encoded or one-hot.
// - Encoded output gives matching word's address.
// - Unencoded uses sixteen lines over two cycles.
// - Unencoded compares 31 bits, one selects bank.
// - Bank one odd words, zero even words.
// - Single-match: write two cycles, search one.
// - Multiple-match: sixteen lines per cycle, two cycles.
// - Fast multiple-match: one cycle, sixteen words.
// - Contents loadable at configuration or runtime.
// - Don't-care write takes a third cycle.
// - Registers insertable on each data/control path.
// - Input and output sides clocked separately; here one clock, only search results paced by out_div ticks.
// - Read-only use as preloaded lookup table.
// - High-speed or low-power; unused block powered down.
//
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
module cam_memory_block (
  // Clock and resets
  input wire logic clk,
  input wire logic rst,
  input wire logic global_clr,
  // Avalon-MM register slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Configuration preload
  input wire cam_pkg::cfg_s cfg,
  // Search result and power state
  output cam_pkg::res_s result,
  output logic power_down
);
  cam_pkg::ctrl_s ctrl_q;
  cam_pkg::state_e st_q;
  cam_pkg::op_e op_q;
  cam_pkg::op_e cmd_op;
  cam_pkg::res_s res_q;
  cam_pkg::res_s res_d;
  logic [31:0] readdata_q;
  logic [31:0] rdata_d;
  logic waitrequest_q;
  logic pdn_q;
  logic [31:0] wdata_q;
  logic [31:0] wmask_q;
  logic [31:0] op_data_q;
  logic [31:0] op_mask_q;
  logic [8:0] addr_q;
  logic [8:0] cmd_addr;
  logic has_dc_q;
  logic err_q;
  logic local_clr_q;
  logic [2:0] prep_q;
  logic [2:0] prep_n;
  logic [1:0] wcnt_q;
  logic [3:0] div_q;
  logic out_tick;
  logic clr;
  logic req;
  logic take;
  logic wr_take;
  logic cmd_wr;
  logic cam_op;
  logic ram_op;
  logic legal;
  logic accept;
  logic refuse;
  logic commit;
  logic bank_sel;
  logic [15:0] lines_d;
  logic [31:0] hits;
  logic [31:0] ign;
  logic [31:0] cam_vld_q;
  logic [31:0] cam_data [0:cam_pkg::WORDS-1];
  logic [31:0] cam_mask [0:cam_pkg::WORDS-1];
  logic [cam_pkg::RAM_BITS-1:0] ram_mem [0:cam_pkg::RAM_DEPTH-1];
  logic [cam_pkg::RAM_BITS-1:0] ram_rd_q;

  function automatic logic [4:0] first_hit(input logic [31:0] h);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (h[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  // Line k carries word 2k+sel, so two banks cover all 32 words
  function automatic logic [15:0] bank_lines(input logic [31:0] h,
                                             input logic sel);
    logic [15:0] l;
    l = 16'h0000;
    for (int k = 0; k < 16; k++) begin
      l[k] = h[2*k + int'(sel)];
    end
    return l;
  endfunction

  function automatic cam_pkg::state_e run_state(input cam_pkg::op_e op);
    cam_pkg::state_e s;
    s = cam_pkg::S_IDLE;
    if (op == cam_pkg::OP_CAM_WR) begin
      s = cam_pkg::S_WR;
    end else if (op == cam_pkg::OP_SEARCH) begin
      s = cam_pkg::S_SRCH;
    end else if (op == cam_pkg::OP_RAM_WR || op == cam_pkg::OP_RAM_RD) begin
      s = cam_pkg::S_RAM;
    end
    return s;
  endfunction

  assign avs_readdata = readdata_q;
  assign avs_waitrequest = waitrequest_q;
  assign result = res_q;
  assign power_down = pdn_q;

  // Chip-wide, global and local clears share one path
  assign clr = rst | global_clr | local_clr_q;

  // Avalon handshake: two cycles per access, no wait beyond that
  assign req = avs_read | avs_write;
  assign take = req & ~waitrequest_q;
  assign wr_take = avs_write & take;

  always_ff @(posedge clk) begin
    if (rst) begin
      waitrequest_q <= 1'b1;
    end else begin
      waitrequest_q <= ~(req & waitrequest_q);
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (avs_address)
      cam_pkg::OFS_CTRL: rdata_d = ctrl_q;
      cam_pkg::OFS_WDATA: rdata_d = wdata_q;
      cam_pkg::OFS_WMASK: rdata_d = wmask_q;
      cam_pkg::OFS_STATUS: begin
        rdata_d[cam_pkg::ST_BUSY] = (st_q != cam_pkg::S_IDLE);
        rdata_d[cam_pkg::ST_MATCH] = res_q.match;
        rdata_d[cam_pkg::ST_ERR] = err_q;
        rdata_d[cam_pkg::ST_PDN] = pdn_q;
        rdata_d[cam_pkg::ST_ADDR_LSB +: 5] = res_q.addr;
      end
      cam_pkg::OFS_RESULT: begin
        rdata_d[15:0] = res_q.lines;
        rdata_d[cam_pkg::RES_ADDR_LSB +: 5] = res_q.addr;
        rdata_d[cam_pkg::RES_MATCH] = res_q.match;
      end
      cam_pkg::OFS_RAMDATA: rdata_d[cam_pkg::RAM_BITS-1:0] = ram_rd_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      readdata_q <= 32'h0000_0000;
    end else if (avs_read & waitrequest_q) begin
      readdata_q <= rdata_d;
    end
  end

  // Software-visible registers
  always_ff @(posedge clk) begin
    if (clr) begin
      ctrl_q <= cam_pkg::CTRL_RST;
      wdata_q <= cam_pkg::WORD_RST;
      wmask_q <= cam_pkg::WORD_RST;
    end else if (wr_take) begin
      if (avs_address == cam_pkg::OFS_CTRL) begin
        ctrl_q <= {16'h0000, avs_writedata[15:0]};
      end
      if (avs_address == cam_pkg::OFS_WDATA) begin
        wdata_q <= avs_writedata;
      end
      if (avs_address == cam_pkg::OFS_WMASK) begin
        wmask_q <= avs_writedata;
      end
    end
  end

  // Command decode and acceptance
  assign cmd_wr = wr_take & (avs_address == cam_pkg::OFS_CMD);
  assign cmd_op = cam_pkg::op_e'(avs_writedata[cam_pkg::CMD_OP_LSB +: 3]);
  assign cmd_addr = avs_writedata[cam_pkg::CMD_ADDR_LSB +: 9];
  assign cam_op = (cmd_op == cam_pkg::OP_CAM_WR) |
                  (cmd_op == cam_pkg::OP_SEARCH);
  assign ram_op = (cmd_op == cam_pkg::OP_RAM_WR) |
                  (cmd_op == cam_pkg::OP_RAM_RD);

  always_comb begin
    legal = 1'b0;
    if (cam_op && ctrl_q.mode != cam_pkg::MODE_RAM) begin
      legal = 1'b1;
      if (cmd_op == cam_pkg::OP_CAM_WR) begin
        // Fast mode owns only the lower sixteen words
        legal = (cmd_addr[8:5] == 4'h0) &&
                !(ctrl_q.mode == cam_pkg::MODE_FAST && cmd_addr[4]);
      end
    end else if (ram_op && ctrl_q.mode == cam_pkg::MODE_RAM) begin
      legal = !(cmd_op == cam_pkg::OP_RAM_WR && ctrl_q.rom_lock);
    end
  end

  // Powered-down block refuses all commands but clear
  assign accept = cmd_wr & legal & ctrl_q.enable &
                  (st_q == cam_pkg::S_IDLE);
  assign refuse = cmd_wr & (cmd_op != cam_pkg::OP_CLEAR) & ~accept;

  // Each enabled path register, and low power, adds one cycle
  always_comb begin
    prep_n = {2'h0, ctrl_q.low_power};
    unique case (cmd_op)
      cam_pkg::OP_SEARCH: prep_n = prep_n +
        {2'h0, ctrl_q.reg_opt[cam_pkg::OPT_DIN]} +
        {2'h0, ctrl_q.reg_opt[cam_pkg::OPT_DOUT]};
      cam_pkg::OP_CAM_WR, cam_pkg::OP_RAM_WR: prep_n = prep_n +
        {2'h0, ctrl_q.reg_opt[cam_pkg::OPT_DIN]} +
        {2'h0, ctrl_q.reg_opt[cam_pkg::OPT_WADDR]} +
        {2'h0, ctrl_q.reg_opt[cam_pkg::OPT_WE]};
      cam_pkg::OP_RAM_RD: prep_n = prep_n +
        {2'h0, ctrl_q.reg_opt[cam_pkg::OPT_RADDR]} +
        {2'h0, ctrl_q.reg_opt[cam_pkg::OPT_RD_STB]} +
        {2'h0, ctrl_q.reg_opt[cam_pkg::OPT_DOUT]};
      default: prep_n = 3'h0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      local_clr_q <= 1'b0;
    end else begin
      local_clr_q <= cmd_wr & (cmd_op == cam_pkg::OP_CLEAR);
    end
  end

  // Error flag: a new refusal wins over a same-cycle clear
  always_ff @(posedge clk) begin
    if (clr) begin
      err_q <= 1'b0;
    end else begin
      err_q <= refuse | (err_q & ~(wr_take &
        (avs_address == cam_pkg::OFS_STATUS) &
        avs_writedata[cam_pkg::ST_ERR]));
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      pdn_q <= 1'b1;
    end else begin
      pdn_q <= ~ctrl_q.enable;
    end
  end

  // Output-side rate: results leave only on divider ticks
  // Compare by magnitude, so shrinking the ratio never waits for a wrap
  assign out_tick = (div_q >= ctrl_q.out_div);

  always_ff @(posedge clk) begin
    if (clr || out_tick) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  // Operand capture, so software may reload registers while busy
  always_ff @(posedge clk) begin
    if (clr) begin
      op_q <= cam_pkg::OP_NONE;
      op_data_q <= cam_pkg::WORD_RST;
      op_mask_q <= cam_pkg::WORD_RST;
      addr_q <= 9'h000;
      has_dc_q <= 1'b0;
    end else if (accept) begin
      op_q <= cmd_op;
      op_data_q <= wdata_q;
      op_mask_q <= wmask_q;
      addr_q <= cmd_addr;
      has_dc_q <= |wmask_q;
    end
  end

  assign commit = (st_q == cam_pkg::S_WR) &
    (wcnt_q == (has_dc_q ? cam_pkg::WR_CYC_DC : cam_pkg::WR_CYC) - 2'h1);

  always_ff @(posedge clk) begin
    if (clr || st_q != cam_pkg::S_WR) begin
      wcnt_q <= 2'h0;
    end else begin
      wcnt_q <= wcnt_q + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      prep_q <= 3'h0;
    end else if (accept) begin
      prep_q <= prep_n;
    end else if (st_q == cam_pkg::S_PREP) begin
      prep_q <= prep_q - 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      st_q <= cam_pkg::S_IDLE;
    end else begin
      unique case (st_q)
        cam_pkg::S_IDLE: if (accept) begin
          st_q <= (prep_n == 3'h0) ? run_state(cmd_op) : cam_pkg::S_PREP;
        end
        cam_pkg::S_PREP: if (prep_q == 3'h1) begin
          st_q <= run_state(op_q);
        end
        cam_pkg::S_WR: if (commit) begin
          st_q <= cam_pkg::S_IDLE;
        end
        cam_pkg::S_SRCH: if (out_tick) begin
          st_q <= (ctrl_q.mode == cam_pkg::MODE_MULTI) ?
                  cam_pkg::S_OUT2 : cam_pkg::S_IDLE;
        end
        cam_pkg::S_OUT2: if (out_tick) begin
          st_q <= cam_pkg::S_IDLE;
        end
        cam_pkg::S_RAM: st_q <= cam_pkg::S_IDLE;
        default: st_q <= cam_pkg::S_IDLE;
      endcase
    end
  end

  // Storage: preload during configuration, else the runtime write
  always_ff @(posedge clk) begin
    if (cfg.we && !cfg.ram) begin
      cam_data[cfg.addr[4:0]] <= cfg.data;
      cam_mask[cfg.addr[4:0]] <= cfg.mask;
    end else if (commit) begin
      cam_data[addr_q[4:0]] <= op_data_q;
      cam_mask[addr_q[4:0]] <= op_mask_q;
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      cam_vld_q <= 32'h0000_0000;
    end else if (cfg.we && !cfg.ram) begin
      cam_vld_q[cfg.addr[4:0]] <= 1'b1;
    end else if (commit) begin
      cam_vld_q[addr_q[4:0]] <= 1'b1;
    end
  end

  // The array acts as one 512-entry single-port RAM, one access per command
  always_ff @(posedge clk) begin
    if (cfg.we && cfg.ram) begin
      ram_mem[cfg.addr] <= cfg.data[cam_pkg::RAM_BITS-1:0];
    end else if (st_q == cam_pkg::S_RAM && op_q == cam_pkg::OP_RAM_WR) begin
      ram_mem[addr_q] <= op_data_q[cam_pkg::RAM_BITS-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      ram_rd_q <= '0;
    end else if (st_q == cam_pkg::S_RAM && op_q == cam_pkg::OP_RAM_RD) begin
      ram_rd_q <= ram_mem[addr_q];
    end
  end

  // Bank-select bit takes no part in unencoded compares
  assign ign = ctrl_q.unenc ? (32'h0000_0001 << cam_pkg::BANK_BIT) :
               32'h0000_0000;

  for (genvar i = 0; i < cam_pkg::WORDS; i++) begin : g_word
    cam_word_cmp #(
      .WIDTH(cam_pkg::WIDTH)
    ) u_cmp (
      .key(op_data_q),
      .word(cam_data[i]),
      .dont_care(cam_mask[i] | ign),
      .vld(cam_vld_q[i] & ~(ctrl_q.mode == cam_pkg::MODE_FAST &&
                            i >= cam_pkg::FAST_WORDS)),
      .hit(hits[i])
    );
  end

  // Multi-match walks bank 0 then bank 1; single takes key bit 31
  always_comb begin
    bank_sel = op_data_q[cam_pkg::BANK_BIT];
    if (ctrl_q.mode == cam_pkg::MODE_MULTI) begin
      bank_sel = (st_q == cam_pkg::S_OUT2);
    end
    lines_d = bank_lines(hits, bank_sel);
    if (ctrl_q.mode == cam_pkg::MODE_FAST) begin
      lines_d = hits[15:0];
    end
    res_d.valid = 1'b1;
    res_d.match = |hits;
    // Unencoded multi-match still needs user-side priority decoding; encoded gives the lowest hit
    res_d.addr = ctrl_q.unenc ? 5'h00 : first_hit(hits);
    res_d.lines = ctrl_q.unenc ? lines_d : 16'h0000;
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      res_q <= '0;
    end else if ((st_q == cam_pkg::S_SRCH || st_q == cam_pkg::S_OUT2) &&
                 out_tick) begin
      res_q <= res_d;
    end else begin
      res_q.valid <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (clr);

  a_write_two_cycles: assert property (
    (st_q == cam_pkg::S_WR && wcnt_q == 2'h0 && !has_dc_q) |=>
      (st_q == cam_pkg::S_WR) ##1 (st_q == cam_pkg::S_IDLE))
    else $error("Plain CAM write did not take two cycles");

  a_write_dc_third: assert property (
    (st_q == cam_pkg::S_WR && wcnt_q == 2'h0 && has_dc_q) |=>
      (st_q == cam_pkg::S_WR)[*2] ##1 (st_q == cam_pkg::S_IDLE))
    else $error("Don't-care write did not take three cycles");

  a_match_flag: assert property (
    (st_q == cam_pkg::S_SRCH && out_tick) |=>
      res_q.valid && res_q.match == $past(|hits))
    else $error("Match flag does not follow the compare");

  a_no_match_low: assert property (
    (st_q == cam_pkg::S_SRCH && out_tick && hits == 32'h0000_0000) |=>
      !res_q.match && res_q.lines == 16'h0000)
    else $error("Miss left flag or lines high");

  a_encoded_addr: assert property (
    (st_q == cam_pkg::S_SRCH && out_tick && !ctrl_q.unenc &&
     hits != 32'h0000_0000) |=>
      (($past(hits) >> res_q.addr) & 32'h0000_0001) == 32'h0000_0001 &&
      ($past(hits) & ((32'h0000_0001 << res_q.addr) - 32'h0000_0001)) ==
      32'h0000_0000)
    else $error("Encoded address is not the lowest match");

  a_bank_select: assert property (
    (st_q == cam_pkg::S_SRCH && out_tick && ctrl_q.unenc &&
     ctrl_q.mode == cam_pkg::MODE_SINGLE) |=>
      res_q.lines[1] == $past(hits[2 + int'(op_data_q[31])]))
    else $error("Bank select picked the wrong word parity");

  a_multi_two_out: assert property (
    (st_q == cam_pkg::S_SRCH && out_tick &&
     ctrl_q.mode == cam_pkg::MODE_MULTI) |=>
      res_q.valid && st_q == cam_pkg::S_OUT2)
    else $error("Multi-match did not give a second bank");

  a_fast_one_cycle: assert property (
    (st_q == cam_pkg::S_SRCH && out_tick &&
     ctrl_q.mode == cam_pkg::MODE_FAST) |=>
      res_q.valid && st_q == cam_pkg::S_IDLE && hits[31:16] == 16'h0000)
    else $error("Fast search not done in one cycle");

  a_replace_word: assert property (
    (commit && !(cfg.we && !cfg.ram)) |=>
      cam_data[$past(addr_q[4:0])] == $past(op_data_q) &&
      cam_mask[$past(addr_q[4:0])] == $past(op_mask_q))
    else $error("Write did not replace word and mask");

  a_power_down: assert property (
    (cmd_wr && !ctrl_q.enable && cmd_op != cam_pkg::OP_CLEAR) |=>
      err_q && st_q == cam_pkg::S_IDLE)
    else $error("Powered-down block accepted a command");
endmodule

//--- tb/cam_user_logic.sv
// User-logic model beside the CAM: preload driver, result monitor, encoder.
// Assumes the block's clock and a synchronous active-high reset.
module cam_user_logic (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Block side
  input wire cam_pkg::res_s result,
  output cam_pkg::cfg_s cfg
);
  timeunit 1ns;
  timeprecision 1ps;
  cam_pkg::res_s beats[$];
  int beat_cyc[$];
  int cyc;

  initial cfg = '0;

  // Every beat is kept, since valid stands for one cycle only
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!rst && result.valid === 1'b1) begin
      beats.push_back(result);
      beat_cyc.push_back(cyc);
    end
  end

  task automatic load(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    cfg <= '{we: 1'b1, ram: 1'b0, addr: {4'h0, a}, data: d, mask: '0};
    @(posedge clk);
    cfg <= '0;
  endtask

  // Lowest index wins across the even beat and the odd beat
  function automatic logic [5:0] prio(input logic [15:0] ev,
                                      input logic [15:0] od);
    for (int k = 0; k < 16; k++) begin
      if (ev[k]) return 6'(2 * k);
      if (od[k]) return 6'(2 * k + 1);
    end
    return 6'h20;
  endfunction
endmodule

//--- tb/cam_memory_block_tb_top.sv
// Self-checking bench for the CAM block over its register slave.
// Assumes one-cycle waitrequest handshakes and the user-logic model.
module cam_memory_block_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, global_clr;
  logic [7:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, rd;
  cam_pkg::cfg_s cfg;
  cam_pkg::res_s result;
  logic power_down;
  int mismatches, tests_run, t_ack;

  cam_memory_block dut (.clk(clk), .rst(rst), .global_clr(global_clr),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cfg(cfg), .result(result), .power_down(power_down));
  cam_user_logic u (.clk(clk), .rst(rst), .result(result), .cfg(cfg));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic av_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    t_ack = u.cyc;
    avs_write <= 1'b0;
  endtask

  task automatic av_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  // Commands are spaced by polling busy, never by a fixed wait
  task automatic cmd(input logic [31:0] c);
    av_wr(cam_pkg::OFS_CMD, c);
    do av_rd(cam_pkg::OFS_STATUS, rd); while (rd[0] !== 1'b0);
  endtask

  task automatic srch(input logic [31:0] key);
    av_wr(cam_pkg::OFS_WDATA, key);
    u.beats.delete();
    u.beat_cyc.delete();
    cmd(32'h0000_0002);
  endtask

  task automatic beat(input int i, input logic m, input logic [4:0] a,
                      input logic [15:0] l, input int lat);
    cam_pkg::res_s b;
    chk("beat present", 32'(u.beats.size() > i), 32'h0000_0001);
    if (u.beats.size() > i) begin
      b = u.beats[i];
      chk("match", 32'(b.match), 32'(m));
      if (m) chk("addr", 32'(b.addr), 32'(a));
      chk("lines", 32'(b.lines), 32'(l));
      chk("latency", u.beat_cyc[i] - t_ack, lat + 1);
    end
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    chk("watchdog", 32'h0000_0001, 32'h0000_0000);
    tally_and_finish();
  end

  initial begin
    rst = 1'b1;
    global_clr = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("power_down", 32'(power_down), 32'h0000_0001);
    chk("result", 32'(result), 32'h0000_0000);
    av_rd(cam_pkg::OFS_CTRL, rd);
    chk("ctrl reset", rd, 32'h0000_0000);
    av_rd(8'h40, rd);
    chk("unmapped", rd, 32'h0000_0000);
    cmd(32'h0000_0002);
    av_rd(cam_pkg::OFS_STATUS, rd);
    chk("off refuse", 32'(rd[2]), 32'h0000_0001);
    av_wr(cam_pkg::OFS_STATUS, 32'h0000_0004);
    u.load(5'h03, 32'h0000_fa12);
    av_wr(cam_pkg::OFS_CTRL, 32'h0000_0010);
    repeat (2) @(posedge clk);
    chk("power_up", 32'(power_down), 32'h0000_0000);
    av_wr(cam_pkg::OFS_WDATA, 32'h1234_5678);
    av_wr(cam_pkg::OFS_WMASK, 32'h0000_000f);
    cmd(32'h000e_0001);
    av_wr(cam_pkg::OFS_WMASK, 32'h0000_0000);
    srch(32'h1234_567f);
    beat(0, 1'b1, 5'h0e, 16'h0000, 1);
    chk("single beats", u.beats.size(), 1);
    srch(32'h0000_fa12);
    beat(0, 1'b1, 5'h03, 16'h0000, 1);
    srch(32'h0000_fa13);
    beat(0, 1'b0, 5'h00, 16'h0000, 1);
    av_wr(cam_pkg::OFS_CTRL, 32'h0000_0018);
    srch(32'h0000_fa12);
    beat(0, 1'b1, 5'h03, 16'h0000, 2);
    av_wr(cam_pkg::OFS_CTRL, 32'h0000_1010);
    srch(32'h0000_fa12);
    chk("div beats", u.beats.size(), 1);
    av_wr(cam_pkg::OFS_CTRL, 32'h0000_0014);
    srch(32'h8000_fa12);
    beat(0, 1'b1, 5'h00, 16'h0002, 1);
    srch(32'h0000_fa12);
    beat(0, 1'b1, 5'h00, 16'h0000, 1);
    av_wr(cam_pkg::OFS_WDATA, 32'h0000_fa12);
    cmd(32'h000e_0001);
    av_wr(cam_pkg::OFS_CTRL, 32'h0000_0015);
    srch(32'h0000_fa12);
    beat(0, 1'b1, 5'h00, 16'h0080, 1);
    beat(1, 1'b1, 5'h00, 16'h0002, 2);
    if (u.beats.size() > 1)
      chk("prio", 32'(u.prio(u.beats[0].lines, u.beats[1].lines)), 3);
    srch(32'h1234_567f);
    beat(0, 1'b0, 5'h00, 16'h0000, 1);
    beat(1, 1'b0, 5'h00, 16'h0000, 2);
    av_wr(cam_pkg::OFS_CTRL, 32'h0000_0016);
    cmd(32'h0010_0001);
    av_rd(cam_pkg::OFS_STATUS, rd);
    chk("fast refuse", 32'(rd[2]), 32'h0000_0001);
    av_wr(cam_pkg::OFS_STATUS, 32'h0000_0004);
    srch(32'h0000_fa12);
    beat(0, 1'b1, 5'h00, 16'h4008, 1);
    chk("fast beats", u.beats.size(), 1);
    av_wr(cam_pkg::OFS_CTRL, 32'h0000_0013);
    av_wr(cam_pkg::OFS_WDATA, 32'h0000_00a5);
    cmd(32'h0105_0003);
    av_wr(cam_pkg::OFS_WDATA, 32'h0000_005a);
    cmd(32'h0005_0003);
    cmd(32'h0105_0004);
    av_rd(cam_pkg::OFS_RAMDATA, rd);
    chk("ram upper", rd, 32'h0000_00a5);
    cmd(32'h0005_0004);
    av_rd(cam_pkg::OFS_RAMDATA, rd);
    chk("ram lower", rd, 32'h0000_005a);
    cmd(32'h0000_0005);
    av_rd(cam_pkg::OFS_CTRL, rd);
    chk("local clear", rd, 32'h0000_0000);
    av_wr(cam_pkg::OFS_CTRL, 32'h0000_0010);
    @(posedge clk);
    global_clr <= 1'b1;
    @(posedge clk);
    global_clr <= 1'b0;
    av_rd(cam_pkg::OFS_CTRL, rd);
    chk("ctrl cleared", rd, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk("power_down", 32'(power_down), 32'h0000_0001);
    tally_and_finish();
  end
endmodule
